// >>> verilog/lma_defines.vh
// Purpose: Constants for the logger mission and alarm register block
// Assumes: Byte registers, one per 32-bit word, byte address = index * 4
// Notes: Indexes of the byte registers are kept; bus addresses derive
//
// Functional notes
// - In mission, temp MSB >= high threshold and high enable set sets high flag
// - In mission, temp MSB <= low threshold and low enable set sets low flag
// - In mission, humidity >= high threshold with enable sets humidity high flag
// - In mission, humidity <= low threshold with enable sets humidity low flag
// - Temperature low then high threshold bytes at consecutive registers
// - Humidity low then high threshold bytes at consecutive registers
// - Temp alarm enables in bits 1:0, upper bits read 0, locked in mission
// - Humidity alarm enables in bits 1:0, upper bits read 1, locked in mission
// - Sample unit bit: 0 counts minutes, 1 counts seconds
// - Oscillator enable bit starts or stops clock; upper bits 0; locked
// - Forced conversion or mission start sets oscillator enable
// - Start-on-alarm waits on coarse temp, logs alarm sample uncounted
// - Start-on-alarm works only with temperature logging enabled
// - Rollover wraps log; otherwise logging stops, mission stays running
// - Humidity format bit picks 8 or 16 bit, MSB at lower address
// - Temperature format bit picks 8 or 16 bit, MSB at lower address
// - Humidity base depends on the two formats when both logged
// - Temperature base fixed; humidity uses it when logged alone
// - Mission start refused unless some logging enable is set
// - Mission setup bit layout, bits 7:6 read 1, locked in mission
// - Alarm flags register read-only, battery flag bit 7, bits 6:4 read 1
// - Clear memory clears all five alarm flags together
// - Temperature comparison uses only the result MSB
// - Humidity comparison uses only the reading MSB
`ifndef LMA_DEFINES_VH
`define LMA_DEFINES_VH

// --------------------------------------------------------------
// Register indexes (byte address is four times these)
// --------------------------------------------------------------
`define LMA_IDX_TEMP_LOW_THR 12'h208
`define LMA_IDX_TEMP_HIGH_THR 12'h209
`define LMA_IDX_HUM_LOW_THR 12'h20a
`define LMA_IDX_HUM_HIGH_THR 12'h20b
`define LMA_IDX_TEMP_ALARM_EN 12'h210
`define LMA_IDX_HUM_ALARM_EN 12'h211
`define LMA_IDX_CLOCK_CTRL 12'h212
`define LMA_IDX_MISSION_SETUP 12'h213
`define LMA_IDX_ALARM_FLAGS 12'h214
`define LMA_IDX_COMMAND 12'h240
`define LMA_IDX_STATUS 12'h241
`define LMA_IDX_SAMPLE_COUNT 12'h242

// --------------------------------------------------------------
// Field positions
// --------------------------------------------------------------
`define LMA_CMD_START 0
`define LMA_CMD_STOP 1
`define LMA_CMD_CLEAR 2
`define LMA_CMD_FORCE 3
`define LMA_SET_TEMP_LOG 0
`define LMA_SET_HUM_LOG 1
`define LMA_SET_TEMP_WIDE 2
`define LMA_SET_HUM_WIDE 3
`define LMA_SET_ROLLOVER 4
`define LMA_SET_START_ALARM 5

// --------------------------------------------------------------
// Fixed read bits and log layout
// --------------------------------------------------------------
`define LMA_TEMP_EN_FILL 6'h00
`define LMA_HUM_EN_FILL 6'h3f
`define LMA_CLOCK_FILL 6'h00
`define LMA_SETUP_FILL 2'h3
`define LMA_FLAGS_FILL 3'h7
`define LMA_LOG_BASE 16'h1000
`define LMA_HUM_BASE_SAME 16'h2000
`define LMA_HUM_BASE_T8_H16 16'h1a00
`define LMA_HUM_BASE_T16_H8 16'h2400
`define LMA_LOG_END 16'h3000
`define LMA_RESP_OKAY 2'h0
`define LMA_RESP_SLVERR 2'h2

`endif

// >>> verilog/lma_regs.v
// Purpose: Mission setup, alarm enables and alarm flags behind AXI4-Lite
// Assumes: Samples arrive from same-clock logic, at most one per 5 cycles
// Notes: Byte registers sit in bits 7:0 of each word, sample count in 23:0; upper bits read 0
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "lma_defines.vh"

module lma_regs #(
	parameter ADDR_WIDTH = 14
) (
	input wire aclk,
	input wire aresetn,
	input wire [ADDR_WIDTH-1:0] awaddr,
	input wire awvalid,
	output reg awready,
	input wire [31:0] wdata,
	input wire [3:0] wstrb,
	input wire wvalid,
	output reg wready,
	output reg [1:0] bresp,
	output reg bvalid,
	input wire bready,
	input wire [ADDR_WIDTH-1:0] araddr,
	input wire arvalid,
	output reg arready,
	output reg [31:0] rdata,
	output reg [1:0] rresp,
	output reg rvalid,
	input wire rready,
	input wire sample_valid,
	input wire [15:0] temp_sample,
	input wire [15:0] hum_sample,
	output reg oscillator_enable,
	output reg sample_in_seconds,
	output reg mission_running_flag,
	output reg temp_coarse_mode,
	output reg force_conversion,
	output reg log_write,
	output reg [15:0] log_addr,
	output reg [7:0] log_data
);

	// --------------------------------------------------------------
	// Register state
	// --------------------------------------------------------------
	reg [7:0] temp_low_thr;
	reg [7:0] temp_high_thr;
	reg [7:0] hum_low_thr;
	reg [7:0] hum_high_thr;
	reg temp_high_alarm_enable;
	reg temp_low_alarm_enable;
	reg hum_high_alarm_enable;
	reg hum_low_alarm_enable;
	reg [5:0] mission_setup;
	reg battery_reset_flag;
	reg hum_high_flag;
	reg hum_low_flag;
	reg temp_high_flag;
	reg temp_low_flag;
	reg waiting_alarm;
	reg memory_cleared;
	reg log_full;
	reg start_refused;
	reg [23:0] sample_count;
	reg [15:0] temp_ptr;
	reg [15:0] hum_ptr;
	reg [7:0] rec_byte [0:3];
	reg [15:0] rec_addr [0:3];
	reg [3:0] rec_en;
	reg [1:0] rec_slot;
	reg rec_busy;

	wire temp_logging_enable = mission_setup[`LMA_SET_TEMP_LOG];
	wire hum_logging_enable = mission_setup[`LMA_SET_HUM_LOG];
	wire temp_wide_format = mission_setup[`LMA_SET_TEMP_WIDE];
	wire hum_wide_format = mission_setup[`LMA_SET_HUM_WIDE];
	wire log_rollover = mission_setup[`LMA_SET_ROLLOVER];
	wire start_on_temp_alarm = mission_setup[`LMA_SET_START_ALARM];

	// --------------------------------------------------------------
	// Bus decode
	// --------------------------------------------------------------
	wire wr_fire = awready & awvalid;
	wire rd_fire = arready & arvalid;
	wire [ADDR_WIDTH-3:0] wr_idx = awaddr[ADDR_WIDTH-1:2];
	wire [ADDR_WIDTH-3:0] rd_idx = araddr[ADDR_WIDTH-1:2];
	wire wr_byte = wr_fire & wstrb[0];
	wire [7:0] wbyte = wdata[7:0];
	// Configuration is frozen while a mission runs
	wire cfg_wr = wr_byte & ~mission_running_flag;

	function is_mapped;
		input [ADDR_WIDTH-3:0] idx;
		begin
			case (idx)
				`LMA_IDX_TEMP_LOW_THR, `LMA_IDX_TEMP_HIGH_THR,
				`LMA_IDX_HUM_LOW_THR, `LMA_IDX_HUM_HIGH_THR,
				`LMA_IDX_TEMP_ALARM_EN, `LMA_IDX_HUM_ALARM_EN,
				`LMA_IDX_CLOCK_CTRL, `LMA_IDX_MISSION_SETUP,
				`LMA_IDX_ALARM_FLAGS, `LMA_IDX_COMMAND,
				`LMA_IDX_STATUS, `LMA_IDX_SAMPLE_COUNT: is_mapped = 1'b1;
				default: is_mapped = 1'b0;
			endcase
		end
	endfunction

	wire cmd_wr = wr_byte & (wr_idx == `LMA_IDX_COMMAND);
	wire cmd_start = cmd_wr & wbyte[`LMA_CMD_START] & ~mission_running_flag;
	wire cmd_stop = cmd_wr & wbyte[`LMA_CMD_STOP] & mission_running_flag;
	wire cmd_clear = cmd_wr & wbyte[`LMA_CMD_CLEAR] & ~mission_running_flag;
	wire cmd_force = cmd_wr & wbyte[`LMA_CMD_FORCE];
	wire start_ok = temp_logging_enable | hum_logging_enable;

	// --------------------------------------------------------------
	// AXI4-Lite handshakes
	// --------------------------------------------------------------
	// Address and data are taken together, one write at a time
	always @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= `LMA_RESP_OKAY;
			arready <= 1'b0;
			rvalid <= 1'b0;
			rresp <= `LMA_RESP_OKAY;
		end else begin
			awready <= ~awready & awvalid & wvalid & ~bvalid;
			wready <= ~awready & awvalid & wvalid & ~bvalid;
			if (wr_fire) begin
				bvalid <= 1'b1;
				bresp <= is_mapped(wr_idx) ? `LMA_RESP_OKAY :
					`LMA_RESP_SLVERR;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
			arready <= ~arready & arvalid & ~rvalid;
			if (rd_fire) begin
				rvalid <= 1'b1;
				rresp <= is_mapped(rd_idx) ? `LMA_RESP_OKAY :
					`LMA_RESP_SLVERR;
			end else if (rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	// --------------------------------------------------------------
	// Read data
	// --------------------------------------------------------------
	reg [31:0] next_rdata;
	always @* begin
		next_rdata = 32'h0000_0000;
		case (rd_idx)
			`LMA_IDX_TEMP_LOW_THR: next_rdata[7:0] = temp_low_thr;
			`LMA_IDX_TEMP_HIGH_THR: next_rdata[7:0] = temp_high_thr;
			`LMA_IDX_HUM_LOW_THR: next_rdata[7:0] = hum_low_thr;
			`LMA_IDX_HUM_HIGH_THR: next_rdata[7:0] = hum_high_thr;
			`LMA_IDX_TEMP_ALARM_EN: next_rdata[7:0] = {`LMA_TEMP_EN_FILL,
				temp_high_alarm_enable, temp_low_alarm_enable};
			`LMA_IDX_HUM_ALARM_EN: next_rdata[7:0] = {`LMA_HUM_EN_FILL,
				hum_high_alarm_enable, hum_low_alarm_enable};
			`LMA_IDX_CLOCK_CTRL: next_rdata[7:0] = {`LMA_CLOCK_FILL,
				sample_in_seconds, oscillator_enable};
			`LMA_IDX_MISSION_SETUP: next_rdata[7:0] =
				{`LMA_SETUP_FILL, mission_setup};
			`LMA_IDX_ALARM_FLAGS: next_rdata[7:0] = {battery_reset_flag,
				`LMA_FLAGS_FILL, hum_high_flag, hum_low_flag,
				temp_high_flag, temp_low_flag};
			`LMA_IDX_STATUS: next_rdata[7:0] = {3'h0, start_refused,
				log_full, memory_cleared, waiting_alarm,
				mission_running_flag};
			`LMA_IDX_SAMPLE_COUNT: next_rdata[23:0] = sample_count;
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn)
			rdata <= 32'h0000_0000;
		else if (rd_fire)
			rdata <= next_rdata;
	end

	// --------------------------------------------------------------
	// Configuration registers
	// --------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			temp_low_thr <= 8'h00;
			temp_high_thr <= 8'h00;
			hum_low_thr <= 8'h00;
			hum_high_thr <= 8'h00;
			temp_high_alarm_enable <= 1'b0;
			temp_low_alarm_enable <= 1'b0;
			hum_high_alarm_enable <= 1'b0;
			hum_low_alarm_enable <= 1'b0;
			sample_in_seconds <= 1'b0;
			oscillator_enable <= 1'b0;
			mission_setup <= 6'h00;
			force_conversion <= 1'b0;
		end else begin
			force_conversion <= cmd_force;
			if (cfg_wr) begin
				case (wr_idx)
					`LMA_IDX_TEMP_LOW_THR: temp_low_thr <= wbyte;
					`LMA_IDX_TEMP_HIGH_THR: temp_high_thr <= wbyte;
					`LMA_IDX_HUM_LOW_THR: hum_low_thr <= wbyte;
					`LMA_IDX_HUM_HIGH_THR: hum_high_thr <= wbyte;
					`LMA_IDX_TEMP_ALARM_EN: begin
						temp_high_alarm_enable <= wbyte[1];
						temp_low_alarm_enable <= wbyte[0];
					end
					`LMA_IDX_HUM_ALARM_EN: begin
						hum_high_alarm_enable <= wbyte[1];
						hum_low_alarm_enable <= wbyte[0];
					end
					`LMA_IDX_CLOCK_CTRL: begin
						sample_in_seconds <= wbyte[1];
						oscillator_enable <= wbyte[0];
					end
					`LMA_IDX_MISSION_SETUP: mission_setup <= wbyte[5:0];
					default: ;
				endcase
			end
			// Command wins over a same-cycle oscillator write
			if (cmd_force | (cmd_start & start_ok))
				oscillator_enable <= 1'b1;
		end
	end

	// --------------------------------------------------------------
	// Sample compare and log placement
	// --------------------------------------------------------------
	wire [7:0] temp_msb = temp_sample[15:8];
	wire [7:0] hum_msb = hum_sample[15:8];
	wire temp_on = temp_logging_enable;
	wire hum_on = hum_logging_enable;
	wire hit_temp_high = temp_on & temp_high_alarm_enable &
		(temp_msb >= temp_high_thr);
	wire hit_temp_low = temp_on & temp_low_alarm_enable &
		(temp_msb <= temp_low_thr);
	wire hit_hum_high = hum_on & hum_high_alarm_enable &
		(hum_msb >= hum_high_thr);
	wire hit_hum_low = hum_on & hum_low_alarm_enable &
		(hum_msb <= hum_low_thr);

	reg [15:0] hum_base;
	always @* begin
		hum_base = `LMA_LOG_BASE;
		if (temp_on & hum_on) begin
			if (temp_wide_format == hum_wide_format)
				hum_base = `LMA_HUM_BASE_SAME;
			else if (hum_wide_format)
				hum_base = `LMA_HUM_BASE_T8_H16;
			else
				hum_base = `LMA_HUM_BASE_T16_H8;
		end
	end

	wire [15:0] temp_end = hum_on ? hum_base : `LMA_LOG_END;
	wire [15:0] temp_step = temp_wide_format ? 16'h0002 : 16'h0001;
	wire [15:0] hum_step = hum_wide_format ? 16'h0002 : 16'h0001;
	wire temp_fits = (temp_ptr + temp_step) <= temp_end;
	wire hum_fits = (hum_ptr + hum_step) <= `LMA_LOG_END;
	wire no_room = (temp_on & ~temp_fits) | (hum_on & ~hum_fits);
	wire [15:0] temp_at = temp_fits ? temp_ptr : `LMA_LOG_BASE;
	wire [15:0] hum_at = hum_fits ? hum_ptr : hum_base;

	wire sample_taken = sample_valid & mission_running_flag & ~rec_busy &
		~log_full;
	wire waiting_hit = waiting_alarm & (hit_temp_high | hit_temp_low);
	wire do_log = sample_taken & (~waiting_alarm | waiting_hit) &
		~(no_room & ~log_rollover);
	wire full_now = sample_taken & (~waiting_alarm | waiting_hit) &
		no_room & ~log_rollover;

	// --------------------------------------------------------------
	// Mission state and alarm flags
	// --------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			mission_running_flag <= 1'b0;
			waiting_alarm <= 1'b0;
			temp_coarse_mode <= 1'b0;
			memory_cleared <= 1'b0;
			log_full <= 1'b0;
			start_refused <= 1'b0;
			sample_count <= 24'h000000;
			temp_ptr <= `LMA_LOG_BASE;
			hum_ptr <= `LMA_LOG_BASE;
			// Reset here stands for a power-on event
			battery_reset_flag <= 1'b1;
			hum_high_flag <= 1'b0;
			hum_low_flag <= 1'b0;
			temp_high_flag <= 1'b0;
			temp_low_flag <= 1'b0;
		end else begin
			if (cmd_start) begin
				start_refused <= ~start_ok;
				if (start_ok) begin
					mission_running_flag <= 1'b1;
					memory_cleared <= 1'b0;
					log_full <= 1'b0;
					temp_ptr <= `LMA_LOG_BASE;
					hum_ptr <= hum_base;
					waiting_alarm <= start_on_temp_alarm &
						temp_logging_enable;
					temp_coarse_mode <= start_on_temp_alarm &
						temp_logging_enable;
				end
			end
			if (cmd_stop) begin
				mission_running_flag <= 1'b0;
				temp_coarse_mode <= 1'b0;
			end
			if (cmd_clear) begin
				memory_cleared <= 1'b1;
				sample_count <= 24'h000000;
			end
			// Full memory stops logging; mission stays running
			if (full_now)
				log_full <= 1'b1;
			if (do_log) begin
				temp_ptr <= temp_at + temp_step;
				hum_ptr <= hum_at + hum_step;
				if (waiting_hit) begin
					waiting_alarm <= 1'b0;
					temp_coarse_mode <= 1'b0;
				end else begin
					// The triggering sample is not counted
					sample_count <= sample_count + 24'h000001;
				end
			end
			// Clear first so a same-cycle alarm still lands
			if (cmd_clear) begin
				battery_reset_flag <= 1'b0;
				hum_high_flag <= 1'b0;
				hum_low_flag <= 1'b0;
				temp_high_flag <= 1'b0;
				temp_low_flag <= 1'b0;
			end
			if (sample_taken) begin
				// Sticky until the next clear
				if (hit_temp_high)
					temp_high_flag <= 1'b1;
				if (hit_temp_low)
					temp_low_flag <= 1'b1;
				if (hit_hum_high & ~waiting_alarm)
					hum_high_flag <= 1'b1;
				if (hit_hum_low & ~waiting_alarm)
					hum_low_flag <= 1'b1;
			end
		end
	end

	// --------------------------------------------------------------
	// Record writer, one log byte per cycle
	// --------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			rec_en <= 4'h0;
			rec_busy <= 1'b0;
			rec_slot <= 2'h0;
		end else if (do_log) begin
			rec_en <= {hum_on & hum_wide_format, hum_on,
				temp_on & temp_wide_format, temp_on};
			rec_busy <= 1'b1;
			rec_slot <= 2'h0;
		end else if (rec_busy) begin
			rec_slot <= rec_slot + 2'h1;
			if (rec_slot == 2'h3)
				rec_busy <= 1'b0;
		end
	end

	// Slots 0..3: temp MSB, temp LSB, hum MSB, hum LSB
	always @(posedge aclk) begin
		if (do_log) begin
			rec_byte[0] <= temp_sample[15:8];
			rec_byte[1] <= temp_sample[7:0];
			rec_byte[2] <= hum_sample[15:8];
			rec_byte[3] <= hum_sample[7:0];
			rec_addr[0] <= temp_at;
			rec_addr[1] <= temp_at + 16'h0001;
			rec_addr[2] <= hum_at;
			rec_addr[3] <= hum_at + 16'h0001;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			log_write <= 1'b0;
			log_addr <= 16'h0000;
			log_data <= 8'h00;
		end else begin
			log_write <= rec_busy & rec_en[rec_slot];
			if (rec_busy & rec_en[rec_slot]) begin
				log_addr <= rec_addr[rec_slot];
				log_data <= rec_byte[rec_slot];
			end
		end
	end

endmodule // lma_regs

// >>> test/lma_host.sv
// Purpose: AXI4-Lite host model that issues register traffic
// Assumes: Caller enters each task just after a rising edge
// Notes: Released address and data lines carry inverted junk
`timescale 1ns/1ps
module lma_host (
	input wire aclk,
	output logic [13:0] awaddr,
	output logic awvalid,
	input wire awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire wready,
	input wire [1:0] bresp,
	input wire bvalid,
	output logic bready,
	output logic [13:0] araddr,
	output logic arvalid,
	input wire arready,
	input wire [31:0] rdata,
	input wire [1:0] rresp,
	input wire rvalid,
	output logic rready
);
	initial begin
		{awaddr, awvalid, wdata, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
		wstrb = 4'h1;
	end
	task wr(input [11:0] i, input [7:0] d, output [1:0] r);
		int n;
		awaddr <= {i, 2'h0};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		n = 0;
		do
			@(posedge aclk);
		while (awready !== 1'b1 && ++n < 50);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		awaddr <= ~awaddr;
		wdata <= ~wdata;
		bready <= 1'b1;
		do
			@(posedge aclk);
		while (bvalid !== 1'b1 && ++n < 50);
		r = bresp;
		bready <= 1'b0;
		if (n >= 50)
			tb_logger_mission_alarm_control.hang();
	endtask
	task rd(input [11:0] i, output [31:0] d, output [1:0] r);
		int n;
		araddr <= {i, 2'h0};
		arvalid <= 1'b1;
		n = 0;
		do
			@(posedge aclk);
		while (arready !== 1'b1 && ++n < 50);
		arvalid <= 1'b0;
		araddr <= ~araddr;
		rready <= 1'b1;
		do
			@(posedge aclk);
		while (rvalid !== 1'b1 && ++n < 50);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		if (n >= 50)
			tb_logger_mission_alarm_control.hang();
	endtask
endmodule // lma_host

// >>> test/lma_regs_sva.sv
// Purpose: Port checks of the mission and alarm register block
// Assumes: One clock, synchronous active-low reset
// Notes: Shadows the setup byte from the bus to know the log layout
`timescale 1ns/1ps
`include "lma_defines.vh"
module lma_regs_sva #(
	parameter ADDR_WIDTH = 14
) (
	input wire aclk,
	input wire aresetn,
	input wire [ADDR_WIDTH-1:0] awaddr,
	input wire awready,
	input wire [31:0] wdata,
	input wire [3:0] wstrb,
	input wire wready,
	input wire bvalid,
	input wire bready,
	input wire sample_valid,
	input wire [15:0] temp_sample,
	input wire [15:0] hum_sample,
	input wire oscillator_enable,
	input wire sample_in_seconds,
	input wire mission_running_flag,
	input wire temp_coarse_mode,
	input wire log_write,
	input wire [15:0] log_addr,
	input wire [7:0] log_data
);
	logic [7:0] setup_q;
	logic [7:0] t_msb;
	logic [7:0] h_msb;
	logic both;
	logic [15:0] hbase;
	always @(posedge aclk)
		if (!aresetn)
			setup_q <= 8'h0;
		else if (awready && wready && wstrb[0] && !mission_running_flag
			&& awaddr[ADDR_WIDTH-1:2] == `LMA_IDX_MISSION_SETUP)
			setup_q <= wdata[7:0];
	assign t_msb = temp_sample[15:8];
	assign h_msb = hum_sample[15:8];
	assign both = setup_q[0] & setup_q[1];
	assign hbase = !both ? 16'h1000 : setup_q[2] == setup_q[3] ? 16'h2000
		: setup_q[3] ? 16'h1a00 : 16'h2400;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_write_answer: assert property (awready |-> wready ##1 bvalid)
		else $error("write answer late");
	a_resp_holds: assert property (bvalid && !bready |=> bvalid)
		else $error("write response dropped");
	a_osc_on_start: assert property (
		$rose(mission_running_flag) |-> oscillator_enable)
		else $error("start left oscillator off");
	a_clock_locked: assert property (
		mission_running_flag && $past(mission_running_flag)
		|-> $stable({oscillator_enable, sample_in_seconds}))
		else $error("clock control changed in mission");
	a_start_needs_log: assert property (
		$rose(mission_running_flag) |-> setup_q[1:0] != 2'h0)
		else $error("mission began with no logging");
	a_wait_needs_temp: assert property (
		$rose(temp_coarse_mode) |-> setup_q[5] && setup_q[0])
		else $error("alarm wait without temperature logging");
	a_temp_msb_first: assert property (
		log_write && $past(sample_valid, 2) |-> log_data == $past(t_msb, 2))
		else $error("first log byte not temperature MSB");
	a_hum_msb_first: assert property (
		log_write && $past(sample_valid, 4) |-> log_data == $past(h_msb, 4))
		else $error("humidity log byte not MSB");
	a_temp_region: assert property (
		log_write && $past(sample_valid, 2)
		|-> log_addr >= 16'h1000 && (!both || log_addr < hbase))
		else $error("temperature record outside its region");
	a_hum_region: assert property (
		log_write && $past(sample_valid, 4)
		|-> log_addr >= hbase && log_addr < 16'h3000)
		else $error("humidity record outside its region");
	c_start: cover property ($rose(mission_running_flag));
	c_log: cover property (log_write);
	c_wait: cover property ($rose(temp_coarse_mode));
endmodule // lma_regs_sva
bind lma_regs lma_regs_sva #(.ADDR_WIDTH(ADDR_WIDTH)) u_lma_sva (
	.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awready(awready),
	.wdata(wdata), .wstrb(wstrb), .wready(wready), .bvalid(bvalid),
	.bready(bready), .sample_valid(sample_valid),
	.temp_sample(temp_sample), .hum_sample(hum_sample),
	.oscillator_enable(oscillator_enable),
	.sample_in_seconds(sample_in_seconds),
	.mission_running_flag(mission_running_flag),
	.temp_coarse_mode(temp_coarse_mode), .log_write(log_write),
	.log_addr(log_addr), .log_data(log_data));

// >>> test/tb_logger_mission_alarm_control.sv
// Purpose: Self-checking bench of the mission and alarm registers
// Assumes: Host model speaks AXI4-Lite, samples driven here
// Notes: Log fill uses both 16-bit formats to keep the run short
`timescale 1ns/1ps
`include "lma_defines.vh"
module tb_logger_mission_alarm_control;
	typedef struct {logic [11:0] i; logic [7:0] w; logic [7:0] r;} lma_row_t;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic sample_valid = 1'b0;
	logic [15:0] temp_sample = 16'h0;
	logic [15:0] hum_sample = 16'h0;
	wire [13:0] awaddr, araddr;
	wire [31:0] wdata, rdata;
	wire [3:0] wstrb;
	wire [1:0] bresp, rresp;
	wire awvalid, awready, wvalid, wready, bvalid, bready;
	wire arvalid, arready, rvalid, rready;
	wire oscillator_enable, sample_in_seconds, mission_running_flag;
	wire temp_coarse_mode, log_write, force_conversion;
	wire [15:0] log_addr;
	wire [7:0] log_data;
	int failures = 0;
	int comparisons = 0;
	int nlog = 0;
	int nfc = 0;
	logic [15:0] la;
	logic [7:0] ld;
	logic [1:0] resp;
	logic [31:0] d;
	lma_row_t rows [9] = '{
		'{`LMA_IDX_ALARM_FLAGS, 8'h0f, 8'hf0},
		'{`LMA_IDX_TEMP_LOW_THR, 8'h40, 8'h40},
		'{`LMA_IDX_TEMP_HIGH_THR, 8'h80, 8'h80},
		'{`LMA_IDX_HUM_LOW_THR, 8'h30, 8'h30},
		'{`LMA_IDX_HUM_HIGH_THR, 8'hb0, 8'hb0},
		'{`LMA_IDX_TEMP_ALARM_EN, 8'hff, 8'h03},
		'{`LMA_IDX_HUM_ALARM_EN, 8'h00, 8'hfc},
		'{`LMA_IDX_CLOCK_CTRL, 8'hfe, 8'h02},
		'{`LMA_IDX_MISSION_SETUP, 8'h00, 8'hc0}};
	always #5 aclk = ~aclk;
	always @(posedge aclk) nfc <= nfc + (force_conversion === 1'b1);
	always @(posedge aclk)
		if (log_write === 1'b1) begin
			la <= log_addr;
			ld <= log_data;
			nlog <= nlog + 1;
		end
	lma_host host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
	lma_regs dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .sample_valid(sample_valid),
		.temp_sample(temp_sample), .hum_sample(hum_sample),
		.oscillator_enable(oscillator_enable),
		.sample_in_seconds(sample_in_seconds),
		.mission_running_flag(mission_running_flag),
		.temp_coarse_mode(temp_coarse_mode),
		.force_conversion(force_conversion),
		.log_write(log_write), .log_addr(log_addr), .log_data(log_data));
	task tally_and_finish;
		if (failures == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task hang;
		failures++;
		tally_and_finish();
	endtask
	task chk_val(input string nm, input [31:0] e, input [31:0] g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask
	task chk_bit(input string nm, input e, input g);
		chk_val(nm, {31'h0, e}, {31'h0, g});
	endtask
	task set(input [11:0] i, input [7:0] v);
		host.wr(i, v, resp);
		chk_val("bresp", 32'h0, {30'h0, resp});
	endtask
	task rchk(input string nm, input [11:0] i, input [31:0] e);
		host.rd(i, d, resp);
		chk_val(nm, e, d);
		chk_val("rresp", 32'h0, {30'h0, resp});
	endtask
	task samp(input [15:0] t, input [15:0] h);
		sample_valid <= 1'b1;
		temp_sample <= t;
		hum_sample <= h;
		@(posedge aclk);
		sample_valid <= 1'b0;
		repeat (6) @(posedge aclk);
	endtask
	// Fills the temperature and humidity regions, then one extra sample
	task fill(input [7:0] s, input int add, input [15:0] last);
		int n0;
		set(`LMA_IDX_MISSION_SETUP, s);
		set(`LMA_IDX_COMMAND, 8'h04);
		set(`LMA_IDX_COMMAND, 8'h01);
		repeat (2048) samp(16'h5000, 16'h5000);
		n0 = nlog;
		samp(16'h5100, 16'h5100);
		chk_val("nlog", n0 + add, nlog);
		chk_val("log_addr", {16'h0, last}, {16'h0, la});
		chk_bit("running", 1'b1, mission_running_flag);
		set(`LMA_IDX_COMMAND, 8'h02);
	endtask
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk_bit("running", 1'b0, mission_running_flag);
		foreach (rows[k]) begin
			set(rows[k].i, rows[k].w);
			rchk("reg", rows[k].i, {24'h0, rows[k].r});
		end
		chk_bit("seconds", 1'b1, sample_in_seconds);
		chk_bit("osc", 1'b0, oscillator_enable);
		set(`LMA_IDX_CLOCK_CTRL, 8'h01);
		chk_bit("osc", 1'b1, oscillator_enable);
		host.wr(12'h300, 8'h11, resp);
		chk_val("bresp", 32'h2, {30'h0, resp});
		host.rd(12'h300, d, resp);
		chk_val("rdata", 32'h0, d);
		chk_val("rresp", 32'h2, {30'h0, resp});
		// Mission with alarms
		set(`LMA_IDX_TEMP_ALARM_EN, 8'h02);
		set(`LMA_IDX_HUM_ALARM_EN, 8'h03);
		set(`LMA_IDX_CLOCK_CTRL, 8'h00);
		set(`LMA_IDX_COMMAND, 8'h08);
		chk_bit("osc", 1'b1, oscillator_enable);
		set(`LMA_IDX_CLOCK_CTRL, 8'h00);
		chk_val("nfc", 32'h1, nfc);
		set(`LMA_IDX_MISSION_SETUP, 8'h0b);
		set(`LMA_IDX_COMMAND, 8'h04);
		rchk("flags", `LMA_IDX_ALARM_FLAGS, 32'h70);
		set(`LMA_IDX_COMMAND, 8'h01);
		chk_bit("running", 1'b1, mission_running_flag);
		chk_bit("osc", 1'b1, oscillator_enable);
		set(`LMA_IDX_TEMP_ALARM_EN, 8'h00);
		rchk("temp_en", `LMA_IDX_TEMP_ALARM_EN, 32'h02);
		set(`LMA_IDX_HUM_ALARM_EN, 8'h00);
		rchk("hum_en", `LMA_IDX_HUM_ALARM_EN, 32'hff);
		set(`LMA_IDX_MISSION_SETUP, 8'h00);
		rchk("setup", `LMA_IDX_MISSION_SETUP, 32'hcb);
		set(`LMA_IDX_CLOCK_CTRL, 8'h02);
		rchk("clock", `LMA_IDX_CLOCK_CTRL, 32'h01);
		samp(16'h30ff, 16'h2000);
		rchk("flags", `LMA_IDX_ALARM_FLAGS, 32'h74);
		chk_val("log_addr", 32'h1a01, {16'h0, la});
		samp(16'h80ff, 16'hafff);
		rchk("flags", `LMA_IDX_ALARM_FLAGS, 32'h76);
		samp(16'h6000, 16'h6000);
		rchk("flags", `LMA_IDX_ALARM_FLAGS, 32'h76);
		set(`LMA_IDX_COMMAND, 8'h02);
		chk_bit("running", 1'b0, mission_running_flag);
		set(`LMA_IDX_COMMAND, 8'h04);
		rchk("flags", `LMA_IDX_ALARM_FLAGS, 32'h70);
		// Start with no logging is refused
		set(`LMA_IDX_MISSION_SETUP, 8'h00);
		set(`LMA_IDX_COMMAND, 8'h01);
		chk_bit("running", 1'b0, mission_running_flag);
		host.rd(`LMA_IDX_STATUS, d, resp);
		chk_val("status", 32'h10, d & 32'h11);
		// Start on temperature alarm
		set(`LMA_IDX_TEMP_ALARM_EN, 8'h03);
		set(`LMA_IDX_MISSION_SETUP, 8'h21);
		set(`LMA_IDX_COMMAND, 8'h01);
		samp(16'h6000, 16'h0);
		chk_bit("coarse", 1'b1, temp_coarse_mode);
		chk_val("nlog", 32'h9, nlog);
		samp(16'h90e0, 16'h0);
		chk_bit("coarse", 1'b0, temp_coarse_mode);
		chk_val("log_addr", 32'h1000, {16'h0, la});
		chk_val("log_data", 32'h90, {24'h0, ld});
		rchk("count", `LMA_IDX_SAMPLE_COUNT, 32'h0);
		rchk("flags", `LMA_IDX_ALARM_FLAGS, 32'h72);
		set(`LMA_IDX_COMMAND, 8'h02);
		set(`LMA_IDX_COMMAND, 8'h04);
		set(`LMA_IDX_MISSION_SETUP, 8'h22);
		set(`LMA_IDX_COMMAND, 8'h01);
		chk_bit("coarse", 1'b0, temp_coarse_mode);
		set(`LMA_IDX_COMMAND, 8'h02);
		fill(8'h0f, 0, 16'h2fff);
		fill(8'h1f, 4, 16'h2001);
		tally_and_finish();
	end
endmodule // tb_logger_mission_alarm_control
